// >>> src/asr_consts.svh
// Purpose: Numeric constants of the address space access router.
// Assumes: 32-bit byte addresses, 20 MHz core clock.
// Notes: Definitions only.
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH
// ==========================================================
// Address map
`define ASR_RAM_TOP_BIT 10
`define ASR_RESERVED_TAG 8'hff
`define ASR_BOOT_RECORD_ADDR 32'hfeff_ff30
// ==========================================================
// Structure alignment, as a mask of low address bits
`define ASR_ALIGN4_MASK 32'h0000_0003
`define ASR_ALIGN16_MASK 32'h0000_000f
// ==========================================================
// Processor-state reset values and step sizes
`define ASR_ARITH_RESET 32'h0000_0000
`define ASR_PROCESS_RESET 32'h0000_0000
`define ASR_TRACE_RESET 32'h0000_0000
`define ASR_IPTR_RESET 32'h0000_0000
`define ASR_ONE_WORD 32'h0000_0004
`define ASR_TWO_WORDS 32'h0000_0008
`define ASR_BYTES_PER_BEAT 5'h04
`endif

// >>> src/asr_pkg.sv
// Purpose: Types shared by the address space access router and its bench.
// Assumes: Nothing beyond the constants header.
// Notes: Encodings are fixed; the bench may rely on them.
package asr_pkg;
    // ======================================================
    // Request and answer encodings
    typedef enum logic [1:0] {ASR_LOAD = 2'h0, ASR_STORE = 2'h1, ASR_FETCH = 2'h2, ASR_ATOMIC = 2'h3} asr_kind_type;
    typedef enum logic [2:0] {ASR_BYTE = 3'h0, ASR_SHORT = 3'h1, ASR_WORD = 3'h2, ASR_DOUBLE = 3'h3,
        ASR_TRIPLE = 3'h4, ASR_QUAD = 3'h5} asr_size_type;
    typedef enum logic [1:0] {ASR_OK = 2'h0, ASR_UNALIGNED = 2'h1, ASR_BAD_FETCH = 2'h2} asr_fault_type;
    typedef enum logic [1:0] {ASR_TGT_RAM = 2'h0, ASR_TGT_RES = 2'h1, ASR_TGT_EXT = 2'h2} asr_target_type;
    typedef enum logic [1:0] {ASR_ST_IDLE = 2'h0, ASR_ST_BEAT = 2'h1} asr_state_type;
    typedef enum logic [1:0] {ASR_CSR_ARITH = 2'h0, ASR_CSR_PROCESS = 2'h1, ASR_CSR_TRACE = 2'h2} asr_csr_type;
    typedef enum logic [2:0] {ASR_DS_PROC_TABLE = 3'h0, ASR_DS_INT_TABLE = 3'h1, ASR_DS_FAULT_TABLE = 3'h2,
        ASR_DS_CTRL_TABLE = 3'h3, ASR_DS_STACK = 3'h4, ASR_DS_CTRL_BLOCK = 3'h5} asr_struct_type;
    typedef struct packed {
        asr_kind_type kind;
        asr_size_type size;
        logic big_endian;
        logic [31:0] addr;
        logic [127:0] wdata;
    } asr_req_type;
    typedef struct packed {
        asr_fault_type fault;
        logic [127:0] data;
    } asr_rsp_type;
    typedef struct packed {
        logic [31:0] addr;
        logic we;
        logic [3:0] be;
        logic [31:0] wdata;
    } asr_bus_type;
    typedef struct packed {
        logic load;
        logic advance;
        logic two_words;
        logic brk;
        logic [31:0] target;
    } asr_flow_type;
    typedef struct packed {
        logic we;
        asr_csr_type sel;
        logic [31:0] wdata;
    } asr_csr_wr_type;
endpackage : asr_pkg

// >>> src/asr_router.sv
// Purpose: Routes loads, stores, atomics and fetches by address and keeps processor-state registers.
// Assumes: One request at a time; external and register-space slaves answer with a one-cycle ack.
// Notes: Internal data RAM is not reset.
// Contract
// - No external cycle to top reserved region.
// - Reserved region reaches only memory-mapped registers.
// - Lowest kilobyte data goes to internal RAM.
// - Fetches from lowest kilobyte are refused.
// - No external cycle for internal RAM.
// - Lock low through whole atomic operation.
// - Unaligned load or store completes by splitting.
// - Unaligned fault raised after access completes.
// - Instruction pointer low two bits zero.
// - Pointer addresses instruction's first word low byte.
// - Break saves next instruction in local register two.
// - Default order puts least byte at base.
// - Reversed order only for short and word.
// - Small loads place least bit at bit zero.
// - Multiword loads fill base register first.
// - Register bit zero least, bit 31 most.
// - Sizes byte, short, word, eight, twelve, sixteen.
// - Four 32-bit processor-state registers held.
`timescale 1ns/100ps
`include "asr_consts.svh"
module asr_router (
    input wire logic clk,
    input wire logic resetn,
    input wire logic req_valid,
    output logic req_ready,
    input wire asr_pkg::asr_req_type req,
    output logic rsp_valid,
    output asr_pkg::asr_rsp_type rsp,
    output logic ext_req,
    output logic ext_lock_n,
    input wire logic ext_ack,
    input wire logic [31:0] ext_rdata,
    output logic mmr_req,
    input wire logic mmr_ack,
    input wire logic [31:0] mmr_rdata,
    output asr_pkg::asr_bus_type bus,
    input wire asr_pkg::asr_flow_type flow,
    output logic [31:0] instruction_pointer,
    output logic [31:0] local_register_two,
    input wire asr_pkg::asr_csr_wr_type csr_wr,
    output logic [31:0] arith_controls,
    output logic [31:0] process_controls,
    output logic [31:0] trace_controls,
    input wire asr_pkg::asr_struct_type struct_sel,
    input wire logic [31:0] struct_base,
    output logic struct_align_err,
    output logic [31:0] boot_record_addr
);
    import asr_pkg::*;

    typedef struct packed {
        asr_state_type st;
        asr_kind_type kind;
        asr_size_type size;
        logic big;
        logic unal;
        logic lock;
        logic wr_phase;
        logic [31:0] cur_addr;
        logic [4:0] left;
        logic [4:0] idx;
        logic [127:0] buf_data;
        logic rsp_valid;
        asr_rsp_type rsp;
        logic [31:0] iptr;
        logic [31:0] ret_ptr;
        logic [31:0] arith;
        logic [31:0] process;
        logic [31:0] trace;
    } asr_regs_type;

    asr_regs_type r_ff;
    asr_regs_type nxt_r;
    logic [31:0] ram [0:255];

    // ======================================================
    // Decoding helpers
    function automatic asr_target_type region(input logic [31:0] a);
        if (a[31:`ASR_RAM_TOP_BIT] == 22'h0) begin
            return ASR_TGT_RAM;
        end else if (a[31:24] == `ASR_RESERVED_TAG) begin
            return ASR_TGT_RES;
        end
        return ASR_TGT_EXT;
    endfunction : region

    function automatic logic [4:0] nbytes(input asr_size_type s);
        case (s)
            ASR_BYTE: return 5'h01;
            ASR_SHORT: return 5'h02;
            ASR_WORD: return 5'h04;
            ASR_DOUBLE: return 5'h08;
            ASR_TRIPLE: return 5'h0c;
            default: return 5'h10;
        endcase
    endfunction : nbytes

    function automatic logic misaligned(input logic [31:0] a, input asr_size_type s);
        case (s)
            ASR_BYTE: return 1'b0;
            ASR_SHORT: return a[0];
            ASR_WORD: return a[1:0] != 2'h0;
            ASR_DOUBLE: return a[2:0] != 3'h0;
            default: return a[3:0] != 4'h0;
        endcase
    endfunction : misaligned

    // Reversed byte order touches short and word blocks only.
    function automatic logic [127:0] swap(input logic [127:0] d, input asr_size_type s, input logic big);
        logic [127:0] o;
        o = d;
        if (big && s == ASR_SHORT) begin
            o[15:0] = {d[7:0], d[15:8]};
        end else if (big && s == ASR_WORD) begin
            o[31:0] = {d[7:0], d[15:8], d[23:16], d[31:24]};
        end
        return o;
    endfunction : swap

    // ======================================================
    // Beat datapath
    logic [1:0] lane;
    logic [4:0] beat_n;
    logic [3:0] k;
    logic [3:0] be;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [127:0] rd_buf;
    asr_target_type tgt;
    logic beat_done;
    logic accept;
    asr_target_type req_tgt;
    logic req_unal;

    always_comb begin
        lane = r_ff.cur_addr[1:0];
        beat_n = r_ff.unal ? 5'h01 : ((r_ff.left > `ASR_BYTES_PER_BEAT) ? `ASR_BYTES_PER_BEAT : r_ff.left);
        tgt = region(r_ff.cur_addr);
        rd = (tgt == ASR_TGT_RAM) ? ram[r_ff.cur_addr[9:2]] : ((tgt == ASR_TGT_RES) ? mmr_rdata : ext_rdata);
        be = 4'h0;
        wd = 32'h0;
        rd_buf = r_ff.buf_data;
        k = 4'h0;
        // Least significant byte of the block lands at the lowest address.
        for (int b = 0; b < 4; b++) begin
            k = r_ff.idx[3:0] + 4'(b) - {2'h0, lane};
            if (b >= int'(lane) && b < int'(lane) + int'(beat_n)) begin
                be[b] = 1'b1;
                wd[b*8 +: 8] = r_ff.buf_data[{k, 3'h0} +: 8];
                rd_buf[{k, 3'h0} +: 8] = rd[b*8 +: 8];
            end
        end
        if (r_ff.kind == ASR_ATOMIC) begin
            be = 4'hf;
            wd = r_ff.rsp.data[31:0] + r_ff.buf_data[31:0];
        end
        beat_done = (r_ff.st == ASR_ST_BEAT) && ((tgt == ASR_TGT_RAM) || (tgt == ASR_TGT_RES && mmr_ack)
            || (tgt == ASR_TGT_EXT && ext_ack));
        req_tgt = region(req.addr);
        req_unal = misaligned(req.addr, req.size);
        accept = req_valid && r_ff.st == ASR_ST_IDLE;
    end

    // ======================================================
    // Next-state logic
    always_comb begin
        nxt_r = r_ff;
        nxt_r.rsp_valid = 1'b0;
        if (accept) begin
            nxt_r.kind = req.kind;
            nxt_r.size = (req.kind == ASR_STORE || req.kind == ASR_LOAD) ? req.size : ASR_WORD;
            nxt_r.big = req.big_endian && (req.kind == ASR_LOAD || req.kind == ASR_STORE);
            nxt_r.unal = misaligned(req.addr, nxt_r.size);
            nxt_r.wr_phase = 1'b0;
            nxt_r.cur_addr = req.addr;
            nxt_r.left = nbytes(nxt_r.size);
            nxt_r.idx = 5'h0;
            // Reads start from an empty buffer so short blocks come back zero-extended.
            if (req.kind == ASR_LOAD || req.kind == ASR_FETCH) begin
                nxt_r.buf_data = 128'h0;
            end else begin
                nxt_r.buf_data = swap(req.wdata, nxt_r.size, nxt_r.big);
            end
            nxt_r.rsp = '{fault: ASR_OK, data: 128'h0};
            if (req.kind == ASR_FETCH && req_tgt != ASR_TGT_EXT) begin
                nxt_r.rsp.fault = ASR_BAD_FETCH;
                nxt_r.rsp_valid = 1'b1;
            end else if (req.kind != ASR_ATOMIC || !misaligned(req.addr, ASR_WORD)) begin
                nxt_r.st = ASR_ST_BEAT;
                nxt_r.lock = req.kind == ASR_ATOMIC;
            end else begin
                nxt_r.rsp.fault = ASR_UNALIGNED;
                nxt_r.rsp_valid = 1'b1;
            end
        end
        if (beat_done) begin
            if (r_ff.kind == ASR_ATOMIC) begin
                if (!r_ff.wr_phase) begin
                    nxt_r.rsp.data = {96'h0, rd};
                    nxt_r.wr_phase = 1'b1;
                end else begin
                    nxt_r.st = ASR_ST_IDLE;
                    nxt_r.lock = 1'b0;
                    nxt_r.rsp_valid = 1'b1;
                end
            end else begin
                nxt_r.cur_addr = r_ff.cur_addr + {27'h0, beat_n};
                nxt_r.idx = r_ff.idx + beat_n;
                nxt_r.left = r_ff.left - beat_n;
                nxt_r.buf_data = rd_buf;
                if (r_ff.left == beat_n) begin
                    nxt_r.st = ASR_ST_IDLE;
                    nxt_r.rsp_valid = 1'b1;
                    // Word 0 of the answer is the base register.
                    nxt_r.rsp.data = (r_ff.kind == ASR_STORE) ? 128'h0 : swap(rd_buf, r_ff.size, r_ff.big);
                    nxt_r.rsp.fault = r_ff.unal ? ASR_UNALIGNED : ASR_OK;
                end
            end
        end
        // Break wins over plain flow changes.
        if (flow.brk) begin
            nxt_r.ret_ptr = r_ff.iptr + (flow.two_words ? `ASR_TWO_WORDS : `ASR_ONE_WORD);
            nxt_r.iptr = {flow.target[31:2], 2'h0};
        end else if (flow.load) begin
            nxt_r.iptr = {flow.target[31:2], 2'h0};
        end else if (flow.advance) begin
            nxt_r.iptr = r_ff.iptr + (flow.two_words ? `ASR_TWO_WORDS : `ASR_ONE_WORD);
        end
        if (csr_wr.we) begin
            case (csr_wr.sel)
                ASR_CSR_ARITH: nxt_r.arith = csr_wr.wdata;
                ASR_CSR_PROCESS: nxt_r.process = csr_wr.wdata;
                ASR_CSR_TRACE: nxt_r.trace = csr_wr.wdata;
                default: nxt_r.trace = r_ff.trace;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_ff <= '{st: ASR_ST_IDLE, kind: ASR_LOAD, size: ASR_BYTE, rsp: '{fault: ASR_OK, data: 128'h0},
                iptr: `ASR_IPTR_RESET, arith: `ASR_ARITH_RESET, process: `ASR_PROCESS_RESET,
                trace: `ASR_TRACE_RESET, default: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Internal data RAM takes data writes only; fetches never reach it.
    always_ff @(posedge clk) begin
        if (beat_done && tgt == ASR_TGT_RAM && (r_ff.kind == ASR_STORE || r_ff.wr_phase)) begin
            for (int b = 0; b < 4; b++) begin
                if (be[b]) begin
                    ram[r_ff.cur_addr[9:2]][b*8 +: 8] <= wd[b*8 +: 8];
                end
            end
        end
    end

    // ======================================================
    // Outputs
    always_comb begin
        req_ready = r_ff.st == ASR_ST_IDLE;
        ext_req = r_ff.st == ASR_ST_BEAT && tgt == ASR_TGT_EXT;
        mmr_req = r_ff.st == ASR_ST_BEAT && tgt == ASR_TGT_RES;
        ext_lock_n = !r_ff.lock;
        bus.addr = {r_ff.cur_addr[31:2], 2'h0};
        bus.we = r_ff.kind == ASR_STORE || r_ff.wr_phase;
        bus.be = be;
        bus.wdata = wd;
        rsp_valid = r_ff.rsp_valid;
        rsp = r_ff.rsp;
        instruction_pointer = r_ff.iptr;
        local_register_two = r_ff.ret_ptr;
        arith_controls = r_ff.arith;
        process_controls = r_ff.process;
        trace_controls = r_ff.trace;
        boot_record_addr = `ASR_BOOT_RECORD_ADDR;
        case (struct_sel)
            ASR_DS_PROC_TABLE, ASR_DS_INT_TABLE, ASR_DS_FAULT_TABLE:
                struct_align_err = (struct_base & `ASR_ALIGN4_MASK) != 32'h0;
            default: struct_align_err = (struct_base & `ASR_ALIGN16_MASK) != 32'h0;
        endcase
    end

    // ======================================================
    // Assertions
    sequence s_ram_word_load;
        accept && req.kind == ASR_LOAD && req.size == ASR_WORD && req.addr[31:10] == 22'h0 && req.addr[1:0] == 2'h0;
    endsequence
    sequence s_unal_start;
        accept && req.kind == ASR_LOAD && req_unal && req_tgt == ASR_TGT_RAM;
    endsequence

    a_no_ext_reserved: assert property (@(posedge clk) disable iff (!resetn)
        ext_req |-> bus.addr[31:24] != 8'hff) else $error("External cycle to reserved space.");
    a_mmr_only_reserved: assert property (@(posedge clk) disable iff (!resetn)
        mmr_req |-> bus.addr[31:24] == 8'hff) else $error("Register cycle outside reserved space.");
    a_no_ext_ram: assert property (@(posedge clk) disable iff (!resetn)
        ext_req |-> bus.addr[31:10] != 22'h0) else $error("External cycle to internal RAM.");
    a_ram_load_time: assert property (@(posedge clk) disable iff (!resetn)
        s_ram_word_load |-> !ext_req ##1 !ext_req ##1 (rsp_valid && rsp.fault == ASR_OK))
        else $error("Internal RAM load did not answer in two cycles.");
    a_fetch_ram_refused: assert property (@(posedge clk) disable iff (!resetn)
        (accept && req.kind == ASR_FETCH && req_tgt == ASR_TGT_RAM) |=> (rsp_valid && rsp.fault == ASR_BAD_FETCH))
        else $error("Fetch from internal RAM not refused.");
    a_lock_held: assert property (@(posedge clk) disable iff (!resetn)
        (r_ff.st == ASR_ST_BEAT && r_ff.kind == ASR_ATOMIC) |-> !ext_lock_n)
        else $error("Lock released during atomic operation.");
    a_unal_fault_late: assert property (@(posedge clk) disable iff (!resetn)
        s_unal_start |-> ##[2:17] (rsp_valid && rsp.fault == ASR_UNALIGNED))
        else $error("Unaligned fault missing after split access.");
    a_iptr_aligned: assert property (@(posedge clk) disable iff (!resetn)
        instruction_pointer[1:0] == 2'h0) else $error("Instruction pointer not word aligned.");
    a_break_saves: assert property (@(posedge clk) disable iff (!resetn)
        (flow.brk && !flow.two_words) |=> local_register_two == $past(instruction_pointer) + 32'h4)
        else $error("Return pointer not saved on break.");
    a_byte_load_low: assert property (@(posedge clk) disable iff (!resetn)
        (rsp_valid && r_ff.kind == ASR_LOAD && r_ff.size == ASR_BYTE) |-> rsp.data[127:8] == 120'h0)
        else $error("Byte load not placed at bit zero.");

    a_atomic_unal_refused: assert property (@(posedge clk) disable iff (!resetn)
        (accept && req.kind == ASR_ATOMIC && req.addr[1:0] != 2'h0) |=> (rsp_valid && rsp.fault == ASR_UNALIGNED))
        else $error("Unaligned atomic not refused.");
    a_lock_released: assert property (@(posedge clk) disable iff (!resetn)
        (r_ff.st == ASR_ST_IDLE) |-> ext_lock_n)
        else $error("Lock held while idle.");
    a_fetch_whole_word: assert property (@(posedge clk) disable iff (!resetn)
        (rsp_valid && r_ff.kind == ASR_FETCH) |-> rsp.fault != ASR_UNALIGNED)
        else $error("Fetch answered as unaligned.");
    a_short_load_low: assert property (@(posedge clk) disable iff (!resetn)
        (rsp_valid && r_ff.kind == ASR_LOAD && r_ff.size == ASR_SHORT) |-> rsp.data[127:16] == 112'h0)
        else $error("Short load not placed at bit zero.");
endmodule : asr_router

// >>> verif/asr_mem_model.sv
// Purpose: Far-side model of external memory and the reserved-region register space.
// Assumes: One beat at a time; bus holds steady until the acknowledge edge.
// Notes: Answer delay is set by the bench; read data is scrambled once released.
`timescale 1ns/100ps
module asr_mem_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] delay,
    input wire logic ext_req,
    input wire logic mmr_req,
    input wire asr_pkg::asr_bus_type bus,
    output logic ext_ack,
    output logic [31:0] ext_rdata,
    output logic mmr_ack,
    output logic [31:0] mmr_rdata
);
    import asr_pkg::*;
    // ======================================================
    // Storage and handshake
    logic [7:0] mem [logic [31:0]];
    logic [3:0] wait_ff;
    logic ack_ff;
    logic sel_ext_ff;
    logic [31:0] rdata_ff;
    logic [31:0] word_addr;
    int i;
    assign ext_ack = ack_ff & sel_ext_ff;
    assign mmr_ack = ack_ff & ~sel_ext_ff;
    assign ext_rdata = rdata_ff;
    assign mmr_rdata = rdata_ff;
    assign word_addr = {bus.addr[31:2], 2'h0};
    // Every byte has its own address and lane enable.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_ff <= 1'b0;
            wait_ff <= 4'h0;
            sel_ext_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else if (ack_ff) begin
            // Released data must not look like the last answer.
            ack_ff <= 1'b0;
            wait_ff <= 4'h0;
            rdata_ff <= ~rdata_ff;
        end else if (ext_req | mmr_req) begin
            // A single agent serves beats whole and in order, so no beat is ever split.
            if (wait_ff >= delay) begin
                ack_ff <= 1'b1;
                sel_ext_ff <= ext_req;
                for (i = 0; i < 4; i++) begin
                    rdata_ff[8*i+:8] <= mem.exists(word_addr + i) ? mem[word_addr + i] : 8'h5a;
                    if (bus.we && bus.be[i]) begin
                        mem[word_addr + i] = bus.wdata[8*i+:8];
                    end
                end
            end else begin
                wait_ff <= wait_ff + 4'h1;
            end
        end
    end
endmodule : asr_mem_model

// >>> verif/testbench.sv
// Purpose: Self-checking bench of the address space access router.
// Assumes: Regions under test are written before they are read.
// Notes: A byte-array model predicts every answer and register value.
`timescale 1ns/100ps
module testbench;
    import asr_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    asr_req_type req = '0;
    asr_flow_type flow = '0;
    asr_csr_wr_type csr_wr = '0;
    asr_struct_type struct_sel = ASR_DS_PROC_TABLE;
    logic [31:0] struct_base = 32'h0;
    logic [3:0] delay = 4'h0;
    logic req_ready, rsp_valid, ext_req, ext_lock_n, ext_ack, mmr_req, mmr_ack, struct_align_err;
    logic [31:0] ext_rdata, mmr_rdata, ip, ret, ac, pc, tc, boot_addr;
    asr_rsp_type rsp;
    asr_bus_type bus;
    int error_cnt = 0;
    int num_checks = 0;
    logic [7:0] mem [logic [31:0]];
    logic [31:0] m_ip, m_ret, a, base, v;
    logic [31:0] m_csr [3];
    asr_kind_type cur_kind = ASR_LOAD;
    asr_req_type r;
    asr_flow_type f;
    int k, s;
    always #25 clk = ~clk;
    asr_router dut_u (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp), .ext_req(ext_req), .ext_lock_n(ext_lock_n), .ext_ack(ext_ack),
        .ext_rdata(ext_rdata), .mmr_req(mmr_req), .mmr_ack(mmr_ack), .mmr_rdata(mmr_rdata), .bus(bus),
        .flow(flow), .instruction_pointer(ip), .local_register_two(ret), .csr_wr(csr_wr), .arith_controls(ac),
        .process_controls(pc), .trace_controls(tc), .struct_sel(struct_sel), .struct_base(struct_base),
        .struct_align_err(struct_align_err), .boot_record_addr(boot_addr));
    asr_mem_model mem_u (.clk(clk), .resetn(resetn), .delay(delay), .ext_req(ext_req), .mmr_req(mmr_req),
        .bus(bus), .ext_ack(ext_ack), .ext_rdata(ext_rdata), .mmr_ack(mmr_ack), .mmr_rdata(mmr_rdata));
    // ======================================================
    // Compare and report
    task finish_test;
        if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word
    task chk_rsp(input asr_fault_type ef, input logic [127:0] ed, input bit cd);
        num_checks++;
        if (rsp.fault !== ef || (cd && rsp.data !== ed)) begin
            error_cnt++;
            $display("wrong value at %0t: answer %h/%h expected %h/%h", $time, rsp.fault, rsp.data, ef, ed);
        end
    endtask : chk_rsp
    function automatic int nbytes(input asr_size_type sz);
        case (sz)
            ASR_BYTE: return 1;
            ASR_SHORT: return 2;
            ASR_WORD: return 4;
            ASR_DOUBLE: return 8;
            ASR_TRIPLE: return 12;
            default: return 16;
        endcase
    endfunction : nbytes
    // ======================================================
    // One request, predicted and then driven
    task run_op(input asr_req_type q);
        asr_fault_type ef;
        logic [127:0] ed;
        logic [31:0] sum;
        bit cd, swap, beats;
        int n, j;
        n = (q.kind == ASR_FETCH || q.kind == ASR_ATOMIC) ? 4 : nbytes(q.size);
        swap = q.big_endian && (q.size == ASR_SHORT || q.size == ASR_WORD) && q.kind <= ASR_STORE;
        ef = ASR_OK;
        ed = '0;
        cd = 1'b1;
        beats = 1'b1;
        if (q.kind == ASR_FETCH && (q.addr < 32'h400 || q.addr[31:24] == 8'hff)) begin
            ef = ASR_BAD_FETCH;
            cd = 1'b0;
            beats = 1'b0;
        end else if (q.kind == ASR_ATOMIC && q.addr[1:0] != 2'h0) begin
            ef = ASR_UNALIGNED;
            cd = 1'b0;
            beats = 1'b0;
        end else begin
            if (q.kind <= ASR_STORE && q.addr % (q.size == ASR_TRIPLE ? 16 : n) != 0) ef = ASR_UNALIGNED;
            for (j = 0; j < n; j++) ed[8*j+:8] = mem[q.addr + (swap ? n - 1 - j : j)];
            if (q.kind == ASR_STORE) begin
                cd = 1'b0;
                for (j = 0; j < n; j++) mem[q.addr + (swap ? n - 1 - j : j)] = q.wdata[8*j+:8];
            end
            if (q.kind == ASR_ATOMIC) begin
                sum = ed[31:0] + q.wdata[31:0];
                for (j = 0; j < 4; j++) mem[q.addr + j] = sum[8*j+:8];
            end
        end
        cur_kind = q.kind;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= q;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        j = 0;
        while (rsp_valid !== 1'b1 && j < 300) begin
            if (beats) chk_word({31'h0, req_ready}, 32'h0, "ready while busy");
            @(posedge clk);
            #1;
            j++;
        end
        if (j >= 300) chk_word(32'h0, 32'h1, "answer never came");
        chk_rsp(ef, ed, cd);
    endtask : run_op
    task check_reset;
        m_ip = 32'h0;
        m_ret = 32'h0;
        m_csr = '{32'h0, 32'h0, 32'h0};
        chk_word(ip, 32'h0, "pointer after reset");
        chk_word(ret, 32'h0, "return pointer after reset");
        chk_word(ac | pc | tc, 32'h0, "state registers after reset");
        chk_word({31'h0, ext_lock_n}, 32'h1, "lock after reset");
        chk_word(boot_addr, 32'hfeff_ff30, "boot record address");
    endtask : check_reset
    // ======================================================
    // Bus watch, sampled on the falling edge where everything is settled
    always @(negedge clk) begin
        if (resetn) begin
            chk_word({30'h0, ip[1:0]}, 32'h0, "pointer low bits");
            if (ext_req === 1'b1) begin
                chk_word({31'h0, ext_lock_n}, {31'h0, cur_kind != ASR_ATOMIC}, "lock level");
                chk_word({31'h0, bus.addr < 32'h400 || bus.addr[31:24] == 8'hff}, 32'h0, "bus address");
            end
            if (mmr_req === 1'b1) chk_word({24'h0, bus.addr[31:24]}, 32'hff, "register space address");
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        chk_word(32'h0, 32'h1, "run did not finish");
        finish_test;
    end
    // ======================================================
    // Main sequence
    initial begin
        void'($urandom(32'h540d7417));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        #1;
        check_reset;
        for (k = 0; k < 448; k++) begin
            r = '0;
            r.kind = ASR_STORE;
            r.size = ASR_WORD;
            r.addr = k < 256 ? k * 4 : (k < 320 ? 32'h1000 : 32'hff00_0000) + (k % 64) * 4;
            r.wdata = {96'h0, $urandom};
            run_op(r);
        end
        for (k = 0; k < 400; k++) begin
            s = $urandom % 3;
            base = s == 0 ? 32'h0 : (s == 1 ? 32'h1000 : 32'hff00_0000);
            r.addr = base + $urandom % (s == 0 ? 32'h3f0 : 32'hf0);
            r.kind = asr_kind_type'($urandom % 4);
            r.size = asr_size_type'($urandom % 6);
            r.big_endian = $urandom % 2;
            r.wdata = {$urandom, $urandom, $urandom, $urandom};
            if (r.kind == ASR_FETCH || (r.kind == ASR_ATOMIC && $urandom % 4 != 0)) r.addr[1:0] = 2'h0;
            delay = $urandom % 4;
            run_op(r);
        end
        for (k = 0; k < 40; k++) begin
            f = '0;
            f.target = $urandom;
            f.two_words = $urandom % 2;
            s = $urandom % 3;
            f.load = s == 0;
            f.advance = s == 1;
            f.brk = s == 2;
            v = f.two_words ? 32'h8 : 32'h4;
            if (f.brk) m_ret = m_ip + v;
            m_ip = f.advance ? m_ip + v : {f.target[31:2], 2'h0};
            @(posedge clk);
            flow <= f;
            @(posedge clk);
            flow <= '0;
            #1;
            chk_word(ip, m_ip, "pointer");
            chk_word(ret, m_ret, "return pointer");
        end
        for (k = 0; k < 6; k++) begin
            v = $urandom;
            m_csr[k % 3] = v;
            @(posedge clk);
            csr_wr <= '{we: 1'b1, sel: asr_csr_type'(k % 3), wdata: v};
            @(posedge clk);
            csr_wr <= '0;
            #1;
            chk_word(ac, m_csr[0], "arithmetic controls");
            chk_word(pc, m_csr[1], "process controls");
            chk_word(tc, m_csr[2], "trace controls");
        end
        for (k = 0; k < 24; k++) begin
            a = $urandom;
            @(posedge clk);
            struct_sel <= asr_struct_type'(k % 6);
            struct_base <= a;
            #1;
            chk_word({31'h0, struct_align_err}, {31'h0, (a & (k % 6 < 3 ? 32'h3 : 32'hf)) != 0}, "alignment");
        end
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1;
        check_reset;
        finish_test;
    end
endmodule : testbench
